// ---- core/acc_conversion_control.v ----
// Purpose: control of a 10-bit successive approximation converter over AXI4-Lite
// Assumes: analog core answers a one-cycle conv_start with conv_done and a 10-bit code
// Notes:   the core saturates out-of-range inputs itself; halt_mode gates the converter
`timescale 1ns/100ps
`default_nettype none
`include "acc_map.vh"

// Function
// - on bit powers converter, converts continuously
// - clearing on bit stops conversion
// - conversion end sets done flag, results
// - high result read or csr write clears
// - done read-only, others rw, reset zero
// - rate bit selects divide four or two
// - four-bit channel select drives input mux
// - channel change aborts, clears done, restarts
// - high holds bits 9:2, low 1:0
// - saturated codes pass through unmodified
// - next conversion overwrites both bytes
// - wait mode leaves converter running
// - halt disables converter, needs stabilization
module acc_conversion_control (
  input  wire        clk,            // 40 MHz cpu clock
  input  wire        srst,           // synchronous reset, active high
  input  wire        ce,             // clock enable, freezes all state when low
  input  wire [31:0] s_axi_awaddr,   // write address
  input  wire        s_axi_awvalid,  // write address valid
  output reg         s_axi_awready,  // write address ready
  input  wire [31:0] s_axi_wdata,    // write data
  input  wire [3:0]  s_axi_wstrb,    // write byte strobes
  input  wire        s_axi_wvalid,   // write data valid
  output reg         s_axi_wready,   // write data ready
  output reg  [1:0]  s_axi_bresp,    // write response
  output reg         s_axi_bvalid,   // write response valid
  input  wire        s_axi_bready,   // write response ready
  input  wire [31:0] s_axi_araddr,   // read address
  input  wire        s_axi_arvalid,  // read address valid
  output reg         s_axi_arready,  // read address ready
  output reg  [31:0] s_axi_rdata,    // read data
  output reg  [1:0]  s_axi_rresp,    // read response
  output reg         s_axi_rvalid,   // read data valid
  input  wire        s_axi_rready,   // read data ready
  input  wire        halt_mode,      // device halt request, asynchronous
  input  wire        wait_mode,      // device wait request, asynchronous
  output reg         conv_power,     // converter core power enable
  output reg  [3:0]  channel_select, // analog input multiplexer select
  output reg         conv_clk_en,    // converter clock tick, one cycle
  output reg         conv_start,     // start one conversion, one cycle
  output reg         conv_abort,     // abandon conversion in progress, one cycle
  input  wire        conv_done,      // core finished, asynchronous pulse held >= 3 cycles
  input  wire [9:0]  conv_code       // core result, stable while conv_done high
);

  // ==========================================================
  // control/status and result storage
  reg        done_flag;
  reg        rate_fast;
  reg        converter_on;
  reg [9:0]  result;
  reg        busy;
  reg [1:0]  div_cnt;
  reg        halt_s1;
  reg        halt_s2;
  reg        wait_s1;
  reg        wait_s2;
  reg        done_s1;
  reg        done_s2;
  reg        done_s3;
  reg        aw_held;
  reg        w_held;
  reg [31:0] aw_addr;
  reg [31:0] w_data;
  reg [3:0]  w_strb;
  reg        next_done_flag;
  reg [9:0]  next_result;
  reg [1:0]  next_div_cnt;
  reg        next_clk_en;

  wire       run_enable;
  wire       done_edge;
  wire       wr_fire;
  wire       rd_fire;
  wire       wr_csr;
  wire       wr_csr_byte;
  wire       rd_high;
  wire [7:0] csr_value;
  wire [7:0] wr_byte;
  wire       wr_rate;
  wire       wr_on;
  wire [3:0] wr_channel;
  wire       ch_change;
  wire [1:0] div_limit;

  // ==========================================================
  // synchronisers for asynchronous inputs
  // halt is a level from the power manager, two flops before use
  always @(posedge clk) begin
    if (srst) begin
      halt_s1 <= 1'b0;
      halt_s2 <= 1'b0;
    end else if (ce) begin
      halt_s1 <= halt_mode;
      halt_s2 <= halt_s1;
    end
  end

  // wait is synchronised for a clean level but deliberately changes nothing
  always @(posedge clk) begin
    if (srst) begin
      wait_s1 <= 1'b0;
      wait_s2 <= 1'b0;
    end else if (ce) begin
      wait_s1 <= wait_mode;
      wait_s2 <= wait_s1;
    end
  end

  // done needs a third flop to find its rising edge; only the second feeds logic
  always @(posedge clk) begin
    if (srst) begin
      done_s1 <= 1'b0;
      done_s2 <= 1'b0;
      done_s3 <= 1'b0;
    end else if (ce) begin
      done_s1 <= conv_done;
      done_s2 <= done_s1;
      done_s3 <= done_s2;
    end
  end

  // wait mode is sampled only to show it is deliberately ignored
  assign run_enable = converter_on & ~halt_s2;
  assign done_edge  = done_s2 & ~done_s3;

  // ==========================================================
  // axi write path: address and data may arrive in either order
  assign wr_fire     = aw_held & w_held & ~s_axi_bvalid;
  assign wr_csr      = wr_fire & (aw_addr[11:2] == {2'h0, `ACC_IDX_CSR});
  assign wr_csr_byte = wr_csr & w_strb[0];
  assign wr_byte     = w_data[7:0];
  assign wr_rate     = wr_byte[`ACC_CSR_RATE_BIT];
  assign wr_on       = wr_byte[`ACC_CSR_ON_BIT];
  assign wr_channel  = wr_byte[`ACC_CSR_CH_MSB:0];
  assign ch_change   = wr_csr_byte & (wr_channel != channel_select);
  assign div_limit   = rate_fast ? `ACC_DIV_FAST : `ACC_DIV_SLOW;

  // ready drops once a beat is held, so a second beat waits for the response
  always @(posedge clk) begin
    if (srst) begin
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `ACC_RESP_OKAY;
      aw_held       <= 1'b0;
      w_held        <= 1'b0;
      aw_addr       <= 32'h0000_0000;
      w_data        <= 32'h0000_0000;
      w_strb        <= 4'h0;
    end else if (ce) begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_addr       <= s_axi_awaddr;
        aw_held       <= 1'b1;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_data       <= s_axi_wdata;
        w_strb       <= s_axi_wstrb;
        w_held       <= 1'b1;
        s_axi_wready <= 1'b0;
      end
      if (wr_fire) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (aw_addr[11:2] == {2'h0, `ACC_IDX_CSR}) ? `ACC_RESP_OKAY : `ACC_RESP_SLVERR;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid  <= 1'b0;
        aw_held       <= 1'b0;
        w_held        <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  // ==========================================================
  // axi read path, one read at a time
  assign rd_fire   = s_axi_arvalid & s_axi_arready;
  assign rd_high   = rd_fire & (s_axi_araddr[11:2] == {2'h0, `ACC_IDX_RES_HIGH});
  assign csr_value = {done_flag, rate_fast, converter_on, 1'b0, channel_select};

  // rdata is registered so the answer stands unchanged until rready
  always @(posedge clk) begin
    if (srst) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= `ACC_RESP_OKAY;
    end else if (ce) begin
      if (rd_fire) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid  <= 1'b1;
        s_axi_rresp   <= `ACC_RESP_OKAY;
        case (s_axi_araddr[11:2])
          {2'h0, `ACC_IDX_CSR}:      s_axi_rdata <= {24'h00_0000, csr_value};
          {2'h0, `ACC_IDX_RES_HIGH}: s_axi_rdata <= {24'h00_0000, result[9:2]};
          {2'h0, `ACC_IDX_RES_LOW}:  s_axi_rdata <= {30'h0000_0000, result[1:0]};
          default: begin
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= `ACC_RESP_SLVERR;
          end
        endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid  <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end

  // ==========================================================
  // done flag and result next state
  // a finishing conversion wins over a clear, except when the channel just changed
  always @* begin
    next_done_flag = done_flag;
    next_result    = result;
    if (done_edge && busy && run_enable && !ch_change) begin
      next_done_flag = 1'b1;
      next_result    = conv_code;
    end else if (wr_csr || rd_high || ch_change) begin
      next_done_flag = 1'b0;
    end
  end

  // ==========================================================
  // control register and done flag
  always @(posedge clk) begin
    if (srst) begin
      rate_fast      <= 1'b0;
      converter_on   <= 1'b0;
      channel_select <= 4'h0;
      done_flag      <= 1'b0;
      result         <= `ACC_RES_RESET;
    end else if (ce) begin
      if (wr_csr_byte) begin
        // bit 4 is reserved and not stored; bit 7 ignores writes
        rate_fast      <= wr_rate;
        converter_on   <= wr_on;
        channel_select <= wr_channel;
      end
      done_flag <= next_done_flag;
      result    <= next_result;
    end
  end

  // ==========================================================
  // converter clock and start/done handshake
  // the code is taken three cycles after done rises, so the core must hold it stable that long
  // divider: counts to the limit, then ticks once and wraps
  always @* begin
    next_div_cnt = div_cnt + 2'h1;
    next_clk_en  = 1'b0;
    if (div_cnt >= div_limit) begin
      next_div_cnt = 2'h0;
      next_clk_en  = 1'b1;
    end
  end

  always @(posedge clk) begin
    if (srst) begin
      div_cnt     <= 2'h0;
      conv_clk_en <= 1'b0;
      conv_start  <= 1'b0;
      conv_abort  <= 1'b0;
      conv_power  <= 1'b0;
      busy        <= 1'b0;
    end else if (ce) begin
      conv_power  <= run_enable;
      conv_start  <= 1'b0;
      conv_abort  <= 1'b0;
      conv_clk_en <= 1'b0;
      if (!run_enable) begin
        div_cnt    <= 2'h0;
        conv_abort <= busy;
        busy       <= 1'b0;
      end else if (ch_change) begin
        conv_abort <= busy;
        busy       <= 1'b0;
        div_cnt    <= 2'h0;
      end else begin
        div_cnt     <= next_div_cnt;
        conv_clk_en <= next_clk_en;
        if (busy && done_edge) begin
          busy <= 1'b0;
        end else if (!busy && !done_s2 && div_cnt >= div_limit) begin
          conv_start <= 1'b1;
          busy       <= 1'b1;
        end
      end
    end
  end

endmodule // acc_conversion_control
`default_nettype wire

// ---- core/acc_map.vh ----
// Purpose: register map and constants of the converter control block
// Assumes: byte addresses on a 32-bit AXI4-Lite bus, one register per word
// Notes:   printed offsets are not all multiples of four, so they are indices
`ifndef ACC_MAP_VH
`define ACC_MAP_VH
// register indices as printed, byte address is index times four
`define ACC_IDX_CSR        8'h70
`define ACC_IDX_RES_HIGH   8'h71
`define ACC_IDX_RES_LOW    8'h72
// control/status field positions
`define ACC_CSR_DONE_BIT   7
`define ACC_CSR_RATE_BIT   6
`define ACC_CSR_ON_BIT     5
`define ACC_CSR_CH_MSB     3
`define ACC_CSR_RESET      8'h00
`define ACC_RES_RESET      10'h000
// converter clock divide counts (cpu clock over 4 and over 2)
`define ACC_DIV_SLOW       2'h3
`define ACC_DIV_FAST       2'h1
// axi responses
`define ACC_RESP_OKAY      2'h0
`define ACC_RESP_SLVERR    2'h2
`endif

// ---- dv/acc_checker.sv ----
// Purpose: port timing checks of the converter control block
// Assumes: checks pause while ce is low
// Notes:   bound to the top module
`timescale 1ns/100ps
`default_nettype none
module acc_checker (
  input wire logic        clk,           // clock
  input wire logic        srst,          // sync reset
  input wire logic        ce,            // clock enable
  input wire logic        s_axi_arvalid, // ar valid
  input wire logic        s_axi_arready, // ar ready
  input wire logic        s_axi_rvalid,  // r valid
  input wire logic        s_axi_rready,  // r ready
  input wire logic [31:0] s_axi_rdata,   // read data
  input wire logic        s_axi_bvalid,  // b valid
  input wire logic        s_axi_bready,  // b ready
  input wire logic [1:0]  s_axi_bresp,   // b response
  input wire logic        conv_power,    // core power
  input wire logic        conv_clk_en,   // divider tick
  input wire logic        conv_start,    // start pulse
  input wire logic        conv_abort     // abort pulse
);
  default clocking @(posedge clk); endclocking
  default disable iff (srst || !ce);
  property p_start; conv_start |=> !conv_start; endproperty
  a_start: assert property (p_start) else $error("start too long");
  property p_tick; conv_clk_en |=> !conv_clk_en; endproperty
  a_tick: assert property (p_tick) else $error("tick too long");
  property p_abort; conv_abort |=> !conv_abort; endproperty
  a_abort: assert property (p_abort) else $error("abort too long");
  property p_off; !conv_power |-> !conv_start; endproperty
  a_off: assert property (p_off) else $error("start while off");
  property p_rans; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
  a_rans: assert property (p_rans) else $error("late read");
  property p_rhold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata); endproperty
  a_rhold: assert property (p_rhold) else $error("read data moved");
  property p_rup; s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0; endproperty
  a_rup: assert property (p_rup) else $error("upper bits set");
  property p_bhold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp); endproperty
  a_bhold: assert property (p_bhold) else $error("write resp moved");
endmodule // acc_checker
bind acc_conversion_control acc_checker u_chk (.*);
`default_nettype wire

// ---- dv/acc_core_model.sv ----
// Purpose: behavioural converter core
// Assumes: code and lat set by the bench
// Notes:   code lines wander outside done
`timescale 1ns/100ps
`default_nettype none
module acc_core_model (
  input  wire logic       clk,        // clock
  input  wire logic       srst,       // reset
  input  wire logic       conv_power, // power
  input  wire logic       conv_start, // start
  input  wire logic       conv_abort, // abort
  input  wire logic [9:0] code,       // next code
  input  wire logic [7:0] lat,        // busy cycles
  output var  logic       conv_done,  // finished
  output var  logic [9:0] conv_code   // result
);
  logic [7:0] cnt;
  logic       busy;
  always @(posedge clk) begin
    if (srst) begin
      busy <= 0; conv_done <= 0; cnt <= 8'h0; conv_code <= 10'h155;
    end else if (conv_abort || !conv_power) begin
      busy <= 0; conv_done <= 0;
    end else if (conv_start) begin
      busy <= 1; cnt <= lat;
    end else if (busy && cnt != 8'h0) cnt <= cnt - 8'h1;
    else if (busy) begin
      busy <= 0; conv_done <= 1; cnt <= 8'h4; conv_code <= code;
    end else if (conv_done && cnt != 8'h0) cnt <= cnt - 8'h1;
    else begin
      conv_done <= 0; conv_code <= ~conv_code;
    end
  end
endmodule // acc_core_model
`default_nettype wire

// ---- dv/adc_conversion_control_tb.sv ----
// Purpose: self-checking bench of the converter control block
// Assumes: axi master one access at a time
// Notes:   random codes from a fixed seed
`timescale 1ns/100ps
`default_nettype none
`include "acc_map.vh"
module adc_conversion_control_tb;
  localparam [31:0] A_CSR = {22'h0, `ACC_IDX_CSR, 2'h0};
  localparam [31:0] A_HI  = {22'h0, `ACC_IDX_RES_HIGH, 2'h0};
  localparam [31:0] A_LO  = {22'h0, `ACC_IDX_RES_LOW, 2'h0};
  logic clk = 0, srst = 1, ce = 1, halt_mode = 0, wait_mode = 0;
  logic [31:0] s_axi_awaddr = 0, s_axi_wdata = 0, s_axi_araddr = 0, d;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire conv_power, conv_clk_en, conv_start, conv_abort, conv_done;
  wire [1:0] s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  wire [3:0] channel_select;
  wire [9:0] conv_code;
  logic [9:0] code = 0, c;
  logic [7:0] lat = 8'h14;
  logic [1:0] r;
  integer num_errors = 0, tests_run = 0, seed = 61, n_ab = 0, i, n, stage = 0;
  acc_conversion_control u_dut (.*);
  acc_core_model u_core (.*);
  always #12.5 clk = ~clk;
  always @(posedge clk) if (conv_abort) n_ab <= n_ab + 1;
  function [31:0] hi_of(input [9:0] v); hi_of = {24'h0, v[9:2]}; endfunction
  function [31:0] lo_of(input [9:0] v); lo_of = {30'h0, v[1:0]}; endfunction
  task chk(input [31:0] got, input [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      num_errors++;
    end
  endtask
  task wr(input [31:0] a, input [31:0] v, output [1:0] rs);
    s_axi_awaddr <= a; s_axi_wdata <= v; s_axi_awvalid <= 1; s_axi_wvalid <= 1;
    do begin
      @(posedge clk);
      if (s_axi_awready) s_axi_awvalid <= 0;
      if (s_axi_wready) s_axi_wvalid <= 0;
    end while (!s_axi_bvalid);
    s_axi_bready <= 1; @(posedge clk); rs = s_axi_bresp; s_axi_bready <= 0;
  endtask
  task rd(input [31:0] a, output [31:0] v, output [1:0] rs);
    s_axi_araddr <= a; s_axi_arvalid <= 1;
    do begin @(posedge clk); if (s_axi_arready) s_axi_arvalid <= 0; end while (!s_axi_rvalid);
    s_axi_rready <= 1; @(posedge clk); v = s_axi_rdata; rs = s_axi_rresp; s_axi_rready <= 0;
  endtask
  task waitdone; do rd(A_CSR, d, r); while (d[7] !== 1'b1); endtask
  task endt; stage++; $display("test %0d done", stage); endtask
  task results;
    $display("comparisons %0d mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  initial begin #2000000; num_errors++; results; end
  initial begin
    repeat (5) @(posedge clk); srst <= 0; @(posedge clk);
    for (i = 0; i < 3; i++) begin rd(A_CSR + 4 * i, d, r); chk(d, 0); end
    endt;
    for (i = 0; i < 16; i++) begin wr(A_CSR, i, r); chk(channel_select, i); chk(r, `ACC_RESP_OKAY); end
    rd(A_CSR, d, r); chk(d, 32'hf); endt;
    for (i = 0; i < 2; i++) begin
      wr(A_CSR, 32'h20 | (i << 6), r);
      do @(posedge clk); while (!conv_clk_en);
      n = 0;
      do begin @(posedge clk); n++; end while (!conv_clk_en);
      chk(n, i ? 2 : 4);
    end
    endt;
    for (i = 0; i < 6; i++) begin
      c = (i == 0) ? 10'h3ff : (i == 1) ? 10'h0 : $random(seed);
      code <= c; wr(A_CSR, 32'h60 | i, r); waitdone;
      rd(A_LO, d, r); chk(d, lo_of(c));
      rd(A_HI, d, r); chk(d, hi_of(c));
      rd(A_CSR, d, r); chk(d[7], 0);
    end
    code <= 10'h2a5; waitdone; rd(A_HI, d, r); chk(d, hi_of(10'h2a5)); endt;
    waitdone; wr(A_CSR, 32'h65, r); rd(A_CSR, d, r); chk(d, 32'h65); endt;
    rd(A_CSR + 12, d, r); chk(r, `ACC_RESP_SLVERR); chk(d, 0);
    wr(A_HI, 32'hff, r); chk(r, `ACC_RESP_SLVERR); endt;
    lat <= 8'hc8; n = n_ab; wr(A_CSR, 32'h66, r);
    repeat (20) @(posedge clk);
    wr(A_CSR, 32'h67, r); chk(n_ab > n, 1); chk(channel_select, 7);
    rd(A_CSR, d, r); chk(d, 32'h67); endt;
    lat <= 8'h14; wait_mode <= 1; waitdone; chk(d[7], 1); wait_mode <= 0; endt;
    halt_mode <= 1; repeat (6) @(posedge clk); chk(conv_power, 0);
    halt_mode <= 0; repeat (6) @(posedge clk); chk(conv_power, 1);
    halt_mode <= 1; ce <= 0; repeat (6) @(posedge clk); chk(conv_power, 1);
    ce <= 1; halt_mode <= 0; @(posedge clk);
    wr(A_CSR, 0, r); repeat (3) @(posedge clk); chk(conv_power, 0); endt;
    results;
  end
endmodule // adc_conversion_control_tb
`default_nettype wire
